// File: logic/pdd_defs.vh
`ifndef PDD_DEFS_VH
`define PDD_DEFS_VH

// register byte offsets
`define PDD_OFS_CTRL      12'h000
`define PDD_OFS_STATUS    12'h004
`define PDD_OFS_ADDR_LO   12'h008
`define PDD_OFS_ADDR_HI   12'h00c
`define PDD_OFS_XLAT_CNT  12'h010
`define PDD_OFS_FAULT_CNT 12'h014

// control register fields
`define PDD_CTRL_NXE      0
`define PDD_CTRL_NEST     1
`define PDD_CTRL_EXT_ACCESS_FLAG_ENABLE     2
`define PDD_CTRL_WPE      3
`define PDD_CTRL_LPE      4
`define PDD_CTRL_SERVER   5
`define PDD_CTRL_W        6
`define PDD_CTRL_RESET    6'h00

// status register fields
`define PDD_ST_CODE_LSB   0
`define PDD_ST_MEMTYPE    4
`define PDD_ST_FORM2M     5
`define PDD_ST_LARGE      6
`define PDD_ST_GPA        7

// entry bit positions
`define PDD_B_PRESENT     0
`define PDD_B_RW          1
`define PDD_B_US          2
`define PDD_B_PWT         3
`define PDD_B_PCD         4
`define PDD_B_ACCESSED    5
`define PDD_B_PSIZE       7
`define PDD_B_EXT_ACCESS  10
`define PDD_B_LARGE_SEL   11
`define PDD_B_ADDR_LSB    12
`define PDD_B_RSVD_MSB    51
`define PDD_B_XD          63

// host address width, client and server
`define PDD_HAW_CLIENT    39
`define PDD_HAW_SERVER    46

// fault codes
`define PDD_F_NONE        3'h0
`define PDD_F_NOT_PRESENT 3'h1
`define PDD_F_RESERVED    3'h2
`define PDD_F_USER        3'h3
`define PDD_F_WRITE       3'h4
`define PDD_F_EXEC        3'h5

// axi responses
`define PDD_RESP_OKAY     2'h0
`define PDD_RESP_SLVERR   2'h2

`endif

// File: logic/pdd_entry_check.v
`include "pdd_defs.vh"
`default_nettype none

module pdd_entry_check (
  input  wire [63:0] entry_i,
  input  wire        exec_disable_enable_i,
  input  wire        ext_access_flag_enable_i,
  input  wire        write_protect_enable_i,
  input  wire        large_page_enable_i,
  input  wire        server_haw_i,
  input  wire        req_user_i,
  input  wire        req_write_i,
  input  wire        req_exec_i,
  output reg  [2:0]  fault_code_o,
  output wire [45:0] table_addr_o,
  output wire        page_form_o,
  output wire        large_page_select_bit_o,
  output wire        memtype_bad_o,
  output wire        update_o,
  output wire [63:0] new_entry_o
);

  // mask of bits below the host address width
  function [51:0] pdd_haw_mask;
    input server;
    integer i;
    begin
      pdd_haw_mask = 52'h0;
      for (i = 0; i < 52; i = i + 1) begin
        if (i < (server ? `PDD_HAW_SERVER : `PDD_HAW_CLIENT))
          pdd_haw_mask[i] = 1'b1;
      end
    end
  endfunction

  wire [51:0] haw_mask = pdd_haw_mask(server_haw_i);
  wire        present  = entry_i[`PDD_B_PRESENT];
  // ignored fields 62:52, 9:8 and 6 are never looked at
  wire        rsvd_bad = |(entry_i[51:0] & ~haw_mask);
  wire        xd       = entry_i[`PDD_B_XD];
  wire        us       = entry_i[`PDD_B_US];
  wire        rw       = entry_i[`PDD_B_RW];

  // bit 7 set means the 2mb-page form, which skips the reserved check and the write-back
  assign page_form_o  = entry_i[`PDD_B_PSIZE];
  // address field is haw-1 down to 12, cut to the 4k-aligned base
  assign table_addr_o = {entry_i[45:`PDD_B_ADDR_LSB] & haw_mask[45:12], 12'h000};
  assign large_page_select_bit_o = entry_i[`PDD_B_LARGE_SEL] & large_page_enable_i;
  // only write-back is supported: any other selection is flagged
  assign memtype_bad_o = entry_i[`PDD_B_PCD] | entry_i[`PDD_B_PWT];

  // first hit wins: presence, reserved bits, then the permission checks
  always @* begin
    if (!present)
      fault_code_o = `PDD_F_NOT_PRESENT;
    else if (!page_form_o && rsvd_bad)
      fault_code_o = `PDD_F_RESERVED;
    else if (req_user_i && !us)
      fault_code_o = `PDD_F_USER;
    else if (req_write_i && !rw && (req_user_i || write_protect_enable_i))
      fault_code_o = `PDD_F_WRITE;
    else if (req_exec_i && exec_disable_enable_i && xd)
      fault_code_o = `PDD_F_EXEC;
    else
      fault_code_o = `PDD_F_NONE;
  end

  // accessed always, extended access only when its enable is on
  wire set_acc = ~entry_i[`PDD_B_ACCESSED];
  wire set_ea  = ext_access_flag_enable_i & ~entry_i[`PDD_B_EXT_ACCESS];
  assign update_o = (fault_code_o == `PDD_F_NONE) && !page_form_o && (set_acc || set_ea);
  assign new_entry_o = entry_i
                     | ({63'h0, 1'b1} << `PDD_B_ACCESSED)
                     | ({63'h0, ext_access_flag_enable_i} << `PDD_B_EXT_ACCESS);

endmodule

`default_nettype wire

// File: logic/pdd_top.v
// Functional notes
// - deny execute when enable and exec-disable set
// - ignored entry fields never affect results
// - reserved bits must be zero
// - bits haw-1:12 give next table base
// - nested mode marks address as guest physical
// - bit 11 large-page select, gated by control
// - set extended-access bit when its enable set
// - enable clear: extended-access bit left alone
// - set accessed bit on first use
// - only write-back paging memory type
// - user bit 0 refuses user requests
// - read/write bit gates writes, write-protect too
// - present bit needed to follow pointer
// - entry is table pointer or 2mb page
// - bit 7 set selects 2mb form
// - host address width 39 client, 46 server
`include "pdd_defs.vh"
`default_nettype none

module pdd_top #(
  parameter CNT_W = 32
) (
  input  wire        sys_clk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  // walker side
  input  wire        ent_valid_i,
  output wire        ent_ready_o,
  input  wire [63:0] ent_data_i,
  input  wire        req_user_i,
  input  wire        req_write_i,
  input  wire        req_exec_i,
  output reg         res_valid_o,
  output reg         res_fault_o,
  output reg  [2:0]  res_fault_code_o,
  output reg  [45:0] res_table_addr_o,
  output reg         res_gpa_o,
  output reg         res_large_sel_o,
  output reg         res_page_form_o,
  output reg         wb_valid_o,
  input  wire        wb_ready_i,
  output reg  [63:0] wb_data_o,
  // axi4-lite slave
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  // control bits
  reg  [`PDD_CTRL_W-1:0] ctrl;
  wire exec_disable_enable    = ctrl[`PDD_CTRL_NXE];
  wire nest   = ctrl[`PDD_CTRL_NEST];
  wire ext_access_flag_enable   = ctrl[`PDD_CTRL_EXT_ACCESS_FLAG_ENABLE];
  wire write_protect_enable    = ctrl[`PDD_CTRL_WPE];
  wire lpe    = ctrl[`PDD_CTRL_LPE];
  wire server = ctrl[`PDD_CTRL_SERVER];

  // status state
  reg  [2:0]       last_code;
  reg              memtype_flag;
  reg  [CNT_W-1:0] xlat_cnt;
  reg  [CNT_W-1:0] fault_cnt;

  // decoder outputs
  wire [2:0]  chk_code;
  wire [45:0] chk_addr;
  wire        chk_form;
  wire        chk_large;
  wire        chk_memtype;
  wire        chk_update;
  wire [63:0] chk_entry;

  pdd_entry_check u_check (
    .entry_i                  (ent_data_i),
    .exec_disable_enable_i    (exec_disable_enable),
    .ext_access_flag_enable_i (ext_access_flag_enable),
    .write_protect_enable_i   (write_protect_enable),
    .large_page_enable_i      (lpe),
    .server_haw_i             (server),
    .req_user_i               (req_user_i),
    .req_write_i              (req_write_i),
    .req_exec_i               (req_exec_i),
    .fault_code_o             (chk_code),
    .table_addr_o             (chk_addr),
    .page_form_o              (chk_form),
    .large_page_select_bit_o  (chk_large),
    .memtype_bad_o            (chk_memtype),
    .update_o                 (chk_update),
    .new_entry_o              (chk_entry)
  );

  // a pending write-back blocks the next entry so flag updates stay in order
  assign ent_ready_o = ~wb_valid_o;
  wire ent_take = ce_i & ent_valid_i & ent_ready_o;
  wire ent_fault = (chk_code != `PDD_F_NONE);

  // result stage: one cycle after the entry is taken
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      res_valid_o      <= 1'b0;
      res_fault_o      <= 1'b0;
      res_fault_code_o <= `PDD_F_NONE;
      res_table_addr_o <= 46'h0;
      res_gpa_o        <= 1'b0;
      res_large_sel_o  <= 1'b0;
      res_page_form_o  <= 1'b0;
    end else if (ce_i) begin
      res_valid_o <= ent_take;
      if (ent_take) begin
        res_fault_o      <= ent_fault;
        res_fault_code_o <= chk_code;
        res_page_form_o  <= chk_form & ~ent_fault;
        // no pointer is handed on when the walk aborts
        res_table_addr_o <= (ent_fault | chk_form) ? 46'h0 : chk_addr;
        res_gpa_o        <= nest & ~ent_fault;
        res_large_sel_o  <= chk_large & ~ent_fault & ~chk_form;
      end
    end
  end

  // entry write-back with accessed / extended-access set, held until taken
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      wb_valid_o <= 1'b0;
      wb_data_o  <= 64'h0;
    end else if (ce_i) begin
      if (wb_valid_o && wb_ready_i)
        wb_valid_o <= 1'b0;
      else if (ent_take && chk_update) begin
        wb_valid_o <= 1'b1;
        wb_data_o  <= chk_entry;
      end
    end
  end

  // axi write channel holding registers: address and data taken in either order
  reg        aw_held;
  reg [11:0] aw_addr;
  reg        w_held;
  reg [31:0] w_data;
  reg [3:0]  w_strb;

  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;

  wire aw_take = ce_i & s_axi_awvalid & s_axi_awready;
  wire w_take  = ce_i & s_axi_wvalid & s_axi_wready;
  wire aw_have = aw_held | aw_take;
  wire w_have  = w_held | w_take;
  wire [11:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
  wire [3:0]  wr_strb = w_held ? w_strb : s_axi_wstrb;
  wire        wr_do   = ce_i & aw_have & w_have & ~s_axi_bvalid;

  // address decode shared by read and write
  function pdd_mapped;
    input [11:0] a;
    begin
      case (a)
        `PDD_OFS_CTRL, `PDD_OFS_STATUS, `PDD_OFS_ADDR_LO,
        `PDD_OFS_ADDR_HI, `PDD_OFS_XLAT_CNT, `PDD_OFS_FAULT_CNT:
          pdd_mapped = 1'b1;
        default:
          pdd_mapped = 1'b0;
      endcase
    end
  endfunction

  wire wr_ctrl   = wr_do & (wr_addr == `PDD_OFS_CTRL) & wr_strb[0];
  wire wr_status = wr_do & (wr_addr == `PDD_OFS_STATUS) & wr_strb[0];
  wire wr_xcnt   = wr_do & (wr_addr == `PDD_OFS_XLAT_CNT);
  wire wr_fcnt   = wr_do & (wr_addr == `PDD_OFS_FAULT_CNT);

  // write handshake and response
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      aw_held      <= 1'b0;
      aw_addr      <= 12'h000;
      w_held       <= 1'b0;
      w_data       <= 32'h0;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PDD_RESP_OKAY;
    end else if (ce_i) begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_do) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= pdd_mapped(wr_addr) ? `PDD_RESP_OKAY : `PDD_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control register; host address width bit picks 39 or 46 bits
  always @(posedge sys_clk_i) begin
    if (rst_i)
      ctrl <= `PDD_CTRL_RESET;
    else if (ce_i && wr_ctrl)
      ctrl <= wr_data[`PDD_CTRL_W-1:0];
  end

  // status: last fault code, sticky write-back-only warning (set beats clear)
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      last_code    <= `PDD_F_NONE;
      memtype_flag <= 1'b0;
    end else if (ce_i) begin
      if (ent_take)
        last_code <= chk_code;
      if (ent_take && chk_memtype && !ent_fault)
        memtype_flag <= 1'b1;
      else if (wr_status && wr_data[`PDD_ST_MEMTYPE])
        memtype_flag <= 1'b0;
    end
  end

  // event counters; any write clears, an event in the same cycle still counts
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      xlat_cnt  <= {CNT_W{1'b0}};
      fault_cnt <= {CNT_W{1'b0}};
    end else if (ce_i) begin
      if (wr_xcnt)
        xlat_cnt <= {{(CNT_W-1){1'b0}}, ent_take & ~ent_fault};
      else if (ent_take && !ent_fault)
        xlat_cnt <= xlat_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
      if (wr_fcnt)
        fault_cnt <= {{(CNT_W-1){1'b0}}, ent_take & ent_fault};
      else if (ent_take && ent_fault)
        fault_cnt <= fault_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // read data mux, narrow fields in low bits, rest zero
  reg [31:0] rd_word;
  always @* begin
    rd_word = 32'h0;
    case (s_axi_araddr)
      `PDD_OFS_CTRL:
        rd_word[`PDD_CTRL_W-1:0] = ctrl;
      `PDD_OFS_STATUS: begin
        rd_word[`PDD_ST_CODE_LSB+2:`PDD_ST_CODE_LSB] = last_code;
        rd_word[`PDD_ST_MEMTYPE] = memtype_flag;
        rd_word[`PDD_ST_FORM2M]  = res_page_form_o;
        rd_word[`PDD_ST_LARGE]   = res_large_sel_o;
        rd_word[`PDD_ST_GPA]     = res_gpa_o;
      end
      `PDD_OFS_ADDR_LO:
        rd_word = res_table_addr_o[31:0];
      `PDD_OFS_ADDR_HI:
        rd_word[13:0] = res_table_addr_o[45:32];
      `PDD_OFS_XLAT_CNT:
        rd_word[CNT_W-1:0] = xlat_cnt;
      `PDD_OFS_FAULT_CNT:
        rd_word[CNT_W-1:0] = fault_cnt;
      default:
        rd_word = 32'h0;
    endcase
  end

  // read channel: one read in flight, answered the cycle after the address
  assign s_axi_arready = ~s_axi_rvalid;
  wire ar_take = ce_i & s_axi_arvalid & s_axi_arready;

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `PDD_RESP_OKAY;
    end else if (ce_i) begin
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= pdd_mapped(s_axi_araddr) ? `PDD_RESP_OKAY : `PDD_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// File: verification/pdd_monitor.sv
`include "pdd_defs.vh"
`default_nettype none
module pdd_monitor #(
  parameter CNT_W = 32
) (
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        ent_valid_i,
  input wire logic        ent_ready_o,
  input wire logic [63:0] ent_data_i,
  input wire logic        req_user_i,
  input wire logic        req_write_i,
  input wire logic        res_valid_o,
  input wire logic        res_fault_o,
  input wire logic [2:0]  res_fault_code_o,
  input wire logic [45:0] res_table_addr_o,
  input wire logic        res_gpa_o,
  input wire logic        wb_valid_o,
  input wire logic        wb_ready_i,
  input wire logic [63:0] wb_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // entry taken; clean means present, table form, bits 51:39 clear
  sequence s_take;
    ce_i && ent_valid_i && ent_ready_o;
  endsequence
  sequence s_clean;
    s_take ##0 (ent_data_i[0] && !ent_data_i[7] && ent_data_i[51:39] == 13'h0);
  endsequence
  a_result_pulse: assert property (s_take |=> res_valid_o)
    else $error("no result after entry taken");
  a_absent_fault: assert property (s_take ##0 !ent_data_i[0] |=> res_fault_o &&
    res_fault_code_o == `PDD_F_NOT_PRESENT) else $error("absent entry not faulted");
  a_reserved_fault: assert property (s_take ##0 (ent_data_i[0] && !ent_data_i[7] &&
    ent_data_i[51:46] != 6'h0) |=> res_fault_code_o == `PDD_F_RESERVED)
    else $error("reserved bits not faulted");
  a_user_refused: assert property (s_clean ##0 (!ent_data_i[2] && req_user_i)
    |=> res_fault_code_o == `PDD_F_USER) else $error("user request not refused");
  a_write_refused: assert property (s_clean ##0 (ent_data_i[2:1] == 2'h2 && req_user_i &&
    req_write_i) |=> res_fault_code_o == `PDD_F_WRITE) else $error("user write not refused");
  a_fault_quiet: assert property (res_valid_o && res_fault_o |-> !wb_valid_o &&
    res_table_addr_o == 46'h0 && !res_gpa_o) else $error("faulted result not quiet");
  a_wb_holds: assert property (wb_valid_o && !wb_ready_i |=> wb_valid_o &&
    $stable(wb_data_o)) else $error("write-back dropped before taken");
  a_wb_accessed: assert property (wb_valid_o |-> wb_data_o[5] && !ent_ready_o)
    else $error("write-back without accessed bit");
endmodule
bind pdd_top pdd_monitor #(.CNT_W(CNT_W)) i_mon (.sys_clk_i, .rst_i, .ce_i, .ent_valid_i,
  .ent_ready_o, .ent_data_i, .req_user_i, .req_write_i, .res_valid_o, .res_fault_o,
  .res_fault_code_o, .res_table_addr_o, .res_gpa_o, .wb_valid_o, .wb_ready_i, .wb_data_o);
`default_nettype wire

// File: verification/pdd_mem_model.sv
`default_nettype none
module pdd_mem_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        go_i,
  input  wire logic [63:0] entry_i,
  input  wire logic [3:0]  stall_i,
  input  wire logic        ent_ready_i,
  output var  logic        ent_valid_o,
  output var  logic [63:0] ent_data_o,
  input  wire logic        wb_valid_i,
  input  wire logic [63:0] wb_data_i,
  output var  logic        wb_ready_o,
  output var  logic [63:0] stored_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_cnt;
  // entry held until taken (the clock enable gates the take, as in the block);
  // bus then inverts so stale data never passes
  always @(posedge clk_i) begin
    if (rst_i) begin
      ent_valid_o <= 1'b0;
      ent_data_o <= 64'h0;
    end else if (go_i) begin
      ent_valid_o <= 1'b1;
      ent_data_o <= entry_i;
    end else if (ent_valid_o && ent_ready_i && ce_i) begin
      ent_valid_o <= 1'b0;
      ent_data_o <= ~ent_data_o;
    end
  end
  // write-back accepted after stall_i idle cycles, so slow memory is seen
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ready_o <= 1'b0;
      wait_cnt <= 4'h0;
      stored_o <= 64'h0;
    end else if (wb_valid_i && wb_ready_o && ce_i) begin
      stored_o <= wb_data_i;
      wb_ready_o <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (wb_valid_i && wait_cnt == stall_i) begin
      wb_ready_o <= 1'b1;
    end else if (wb_valid_i) begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

// File: verification/testbench.sv
`include "pdd_defs.vh"
`default_nettype none
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin n_fail++; \
  $display("Error %s expected %h seen %h", nm, exp, got); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i, rst_i, ce_i, ent_valid_i, ent_ready_o, req_user_i, req_write_i, req_exec_i;
  logic res_valid_o, res_fault_o, res_gpa_o, res_large_sel_o, res_page_form_o;
  logic wb_valid_o, wb_ready_i, go, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [63:0] ent_data_i, wb_data_o, ent, stored;
  logic [45:0] res_table_addr_o;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [3:0]  s_axi_wstrb, stall;
  logic [2:0]  res_fault_code_o;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          n_fail = 0;
  int          samples_checked = 0;
  pdd_top i_dut (.sys_clk_i, .rst_i, .ce_i, .ent_valid_i, .ent_ready_o, .ent_data_i,
    .req_user_i, .req_write_i, .req_exec_i, .res_valid_o, .res_fault_o, .res_fault_code_o,
    .res_table_addr_o, .res_gpa_o, .res_large_sel_o, .res_page_form_o, .wb_valid_o,
    .wb_ready_i, .wb_data_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  pdd_mem_model i_mem (.clk_i(sys_clk_i), .rst_i, .ce_i, .go_i(go), .entry_i(ent),
    .stall_i(stall),
    .ent_ready_i(ent_ready_o), .ent_valid_o(ent_valid_i), .ent_data_o(ent_data_i),
    .wb_valid_i(wb_valid_o), .wb_data_i(wb_data_o), .wb_ready_o(wb_ready_i), .stored_o(stored));
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  // register write: address and data released each as taken, then wait for response
  task automatic reg_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge sys_clk_i);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    `CHK("bresp", er, s_axi_bresp)
  endtask
  task automatic reg_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge sys_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    `CHK("rresp", er, s_axi_rresp)
    `CHK("rdata", ed, s_axi_rdata)
  endtask
  // offer one entry, capture the result pulse, let any write-back finish
  task automatic walk(input logic [63:0] e, input logic [2:0] rq, input logic [3:0] st,
                      input logic [2:0] code, input logic [45:0] addr, input logic [3:0] flg);
    int n;
    logic [9:0] got;
    @(posedge sys_clk_i);
    {req_exec_i, req_write_i, req_user_i} <= rq;
    ent <= e;
    stall <= st;
    go <= 1'b1;
    @(posedge sys_clk_i);
    go <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      #1 n++;
    end while (!res_valid_o && n < 8);
    got = {res_valid_o, res_fault_o, res_fault_code_o, res_large_sel_o, res_gpa_o,
           res_page_form_o, wb_valid_o, 1'b0};
    `CHK("table addr", addr, res_table_addr_o)
    while (wb_valid_o && n < 40) begin
      @(posedge sys_clk_i);
      #1 n++;
    end
    `CHK("result", {1'b1, code != 3'h0, code, flg, 1'b0}, got)
  endtask
  task automatic t_regs;
    reg_rd(`PDD_OFS_CTRL, 32'h0, `PDD_RESP_OKAY);
    reg_wr(`PDD_OFS_CTRL, 32'h3f, `PDD_RESP_OKAY);
    reg_wr(12'h100, 32'h0, `PDD_RESP_SLVERR);
    reg_rd(12'h100, 32'h0, `PDD_RESP_SLVERR);
    reg_rd(`PDD_OFS_CTRL, 32'h3f, `PDD_RESP_OKAY);
  endtask
  task automatic t_faults;
    logic [63:0] fe [10] = '{64'h0, 64'h0001_0000_0000_0007, 64'h3, 64'h5, 64'h5, 64'h5,
      64'h8000_0000_0000_0007, 64'h8000_0000_0000_0007, 64'h0100_0000_0007, 64'h0100_0000_0007};
    logic [5:0] fc [10] = '{6'h0, 6'h0, 6'h0, 6'h0, 6'h8, 6'h0, 6'h1, 6'h0, 6'h0, 6'h20};
    logic [2:0] fr [10] = '{3'h0, 3'h0, 3'h1, 3'h3, 3'h2, 3'h2, 3'h4, 3'h4, 3'h0, 3'h0};
    logic [2:0] fx [10] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h4, 3'h0, 3'h5, 3'h0, 3'h2, 3'h0};
    for (int i = 0; i < 10; i++) begin
      reg_wr(`PDD_OFS_CTRL, {26'h0, fc[i]}, `PDD_RESP_OKAY);
      walk(fe[i], fr[i], 4'h0, fx[i], (fx[i] == 3'h0) ? {fe[i][45:12], 12'h0} : 46'h0,
           {3'h0, fx[i] == 3'h0});
    end
    reg_rd(`PDD_OFS_FAULT_CNT, 32'h7, `PDD_RESP_OKAY);
  endtask
  task automatic t_pointer;
    reg_wr(`PDD_OFS_CTRL, 32'h16, `PDD_RESP_OKAY);
    walk(64'h7ff0_0055_5555_5b47, 3'h1, 4'h3, 3'h0, 46'h55_5555_5000, 4'hd);
    `CHK("stored", 64'h7ff0_0055_5555_5f67, stored)
    reg_rd(`PDD_OFS_ADDR_LO, 32'h5555_5000, `PDD_RESP_OKAY);
    reg_wr(`PDD_OFS_CTRL, 32'h20, `PDD_RESP_OKAY);
    walk(64'h7ff0_2a55_5555_5b47, 3'h1, 4'h0, 3'h0, 46'h2a55_5555_5000, 4'h1);
    `CHK("stored", 64'h7ff0_2a55_5555_5b67, stored)
    walk(64'h7ff0_2a55_5555_5b67, 3'h1, 4'h0, 3'h0, 46'h2a55_5555_5000, 4'h0);
    walk(64'h87, 3'h0, 4'h0, 3'h0, 46'h0, 4'h2);
    walk(64'h17, 3'h0, 4'h0, 3'h0, 46'h0, 4'h1);
    reg_rd(`PDD_OFS_STATUS, 32'h10, `PDD_RESP_OKAY);
    reg_wr(`PDD_OFS_STATUS, 32'h10, `PDD_RESP_OKAY);
    reg_rd(`PDD_OFS_STATUS, 32'h0, `PDD_RESP_OKAY);
  endtask
  // entry offered with the clock enable low must wait; a mid-run reset then clears state
  task automatic t_freeze;
    @(posedge sys_clk_i);
    ce_i <= 1'b0;
    {req_exec_i, req_write_i, req_user_i} <= 3'h1;
    ent <= 64'h12_3456_7007;
    stall <= 4'hf;
    go <= 1'b1;
    @(posedge sys_clk_i);
    go <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    #1 `CHK("frozen", 3'h3, {res_valid_o, ent_valid_i, ent_ready_o})
    @(posedge sys_clk_i);
    ce_i <= 1'b1;
    @(posedge sys_clk_i);
    #1;
    `CHK("thawed", {2'h3, 46'h12_3456_7000}, {res_valid_o, wb_valid_o, res_table_addr_o})
    reg_rd(`PDD_OFS_XLAT_CNT, 32'h9, `PDD_RESP_OKAY);
    // reset lands while the slow write-back is still pending
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    #1 `CHK("reset", 3'h1, {res_valid_o, wb_valid_o, ent_ready_o})
    reg_rd(`PDD_OFS_ADDR_LO, 32'h0, `PDD_RESP_OKAY);
    s_axi_wstrb <= 4'he;
    reg_wr(`PDD_OFS_CTRL, 32'h3f, `PDD_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    reg_rd(`PDD_OFS_CTRL, 32'h0, `PDD_RESP_OKAY);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // the whole run needs about 150 cycles
  initial begin
    repeat (6000) @(posedge sys_clk_i);
    n_fail++;
    end_of_test();
  end
  initial begin
    {rst_i, ce_i, s_axi_wstrb} = 6'h3f;
    {req_user_i, req_write_i, req_exec_i, go, ent, stall} = 72'h0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = 47'h0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = 14'h0;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_faults();
    t_pointer();
    t_freeze();
    end_of_test();
  end
endmodule
`default_nettype wire
